/* adcpm_checker.sv */
`timescale 1ns/1ns
module adcpm_checker
  import adcpm_pkg::*;
(
  // Clock and pins
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             cs_n,
  input wire logic             sclk,
  input wire adcpm_pins_type   pins,
  // Core side
  input wire logic             result_valid,
  input wire logic             result_ready,
  input wire adcpm_result_type result,
  input wire logic             track_hold,
  input wire logic             conv_start,
  input wire logic             conv_abort,
  input wire logic             conv_done,
  input wire logic             ref_power_on,
  input wire logic             analog_power_on,
  input wire logic             powered_up,
  input wire adcpm_mode_type   mode
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_fall_drive: assert property ($fell(cs_n) |-> ##[3:6]
    (pins.serial_out_a_oe && pins.serial_out_b_oe)) else $error("lines not driven");
  a_start_zero: assert property (conv_start |-> track_hold && pins.serial_out_a_oe
    && !pins.serial_out_a && !pins.serial_out_b) else $error("bad frame start");
  a_rise_free: assert property ($rose(cs_n) |-> ##[3:6]
    !(pins.serial_out_a_oe || pins.serial_out_b_oe)) else $error("lines not released");
  a_done_driven: assert property (conv_done |=> !conv_done
    && pins.serial_out_a_oe) else $error("lines dropped at done");
  a_full_from_part: assert property ($rose(mode == MODE_FULL)
    |-> $past(mode) == MODE_PARTIAL) else $error("full down not from partial");
  a_part_ref: assert property ((mode == MODE_PARTIAL && cs_n && $past(cs_n, 6))
    |-> ref_power_on && !analog_power_on) else $error("partial power map");
  a_full_dark: assert property ((mode == MODE_FULL && cs_n && $past(cs_n, 6))
    |-> !ref_power_on && !analog_power_on) else $error("full power map");
  a_wake_in_frame: assert property ($rose(mode == MODE_NORMAL)
    |-> !cs_n && !$past(cs_n, 8)) else $error("wake outside held frame");
  a_abort_free: assert property (conv_abort |-> !pins.serial_out_a_oe
    && !pins.serial_out_b_oe && !track_hold) else $error("abort left lines driven");
  a_track_back: assert property (conv_done |-> ##[1:12]
    !track_hold) else $error("no return to track after done");

  c_done: cover property (conv_done);
  c_abort: cover property (conv_abort);
  c_full: cover property ($rose(mode == MODE_FULL));
  c_wake: cover property ($rose(mode == MODE_NORMAL));
endmodule

bind adcpm_power_ctrl adcpm_checker i_adcpm_checker (.clock(clock), .sys_rst(sys_rst),
  .cs_n(cs_n), .sclk(sclk), .pins(pins), .result_valid(result_valid),
  .result_ready(result_ready), .result(result), .track_hold(track_hold),
  .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done),
  .ref_power_on(ref_power_on), .analog_power_on(analog_power_on),
  .powered_up(powered_up), .mode(mode));

/* adcpm_fifo.sv */
`timescale 1ns/1ns
module adcpm_fifo
  import adcpm_pkg::*;
#(
  parameter int WIDTH = 2 * RES_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0]      count_q, count_d;
  logic             push, pop;

  always_comb begin
    in_ready  = (count_q != DEPTH[AW:0]);
    out_valid = (count_q != '0);
    out_data  = mem_q[rd_ptr_q];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wr_ptr_d  = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d  = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
    end
  end

  // Storage carries no reset; only the pointers and the count define what is valid.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

/* adcpm_host.sv */
`timescale 1ns/1ns
module adcpm_host
  import adcpm_pkg::*;
(
  // Clock and pins
  input  wire logic           clock,
  output logic                cs_n,
  output logic                sclk,
  input  wire adcpm_pins_type pins
);
  // ****
  // Serial port
  // ****
  wire logic la = pins.serial_out_a_oe ? pins.serial_out_a : 1'bz;
  wire logic lb = pins.serial_out_b_oe ? pins.serial_out_b : 1'bz;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end

  // The clock stands high between frames; halves of 62 and 63 ns keep edges off the clock.
  task automatic frame(input int n, output logic [32:0] a, output logic [32:0] b);
    a = {33{1'bx}};
    b = {33{1'bx}};
    @(negedge clock);
    #2;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #62;
      a[i] = la;
      b[i] = lb;
      sclk = 1'b0;
      #63;
      sclk = 1'b1;
    end
    #62;
    a[n] = la;
    b[n] = lb;
    cs_n = 1'b1;
    #250;
  endtask
endmodule

/* adcpm_pkg.sv */
package adcpm_pkg;

  // ********************************************************
  // Frame shape
  // ********************************************************
  localparam int          RES_W       = 14;
  localparam int          FRAME_W     = 32;
  localparam int          CNT_W       = 6;
  localparam logic [1:0]  LEAD_ZEROS  = 2'h0;
  localparam logic [5:0]  EDGE_GLITCH = 6'h02;
  localparam logic [5:0]  EDGE_WAKE   = 6'h0a;
  localparam logic [5:0]  EDGE_DONE   = 6'h10;
  localparam logic [5:0]  EDGE_LAST   = 6'h20;
  localparam logic [5:0]  EDGE_SAT    = 6'h3f;

  // ********************************************************
  // Timing and buffer sizes
  // ********************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PART_WAKE_NS    = 200;
  localparam int FULL_WAKE_MS    = 6;
  localparam int PART_WAKE_CYC   = (PART_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WAKE_CYC   = (FULL_WAKE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WAKE_W          = 20;
  localparam int FIFO_DEPTH      = 16;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b001,
    MODE_PARTIAL = 3'b010,
    MODE_FULL    = 3'b100
  } adcpm_mode_type;

  typedef struct packed {
    logic [RES_W-1:0] chan_a;
    logic [RES_W-1:0] chan_b;
  } adcpm_result_type;

  typedef struct packed {
    logic serial_out_a;
    logic serial_out_a_oe;
    logic serial_out_b;
    logic serial_out_b_oe;
  } adcpm_pins_type;

endpackage

/* adcpm_power_ctrl.sv */
// Notes on behaviour
// [RULE_01] Select fall: hold, convert, drive outputs.
// [RULE_02] Two leading zeros, then 14 bits MSB-first.
// [RULE_03] Host keeps select low ten edges.
// [RULE_04] Rise in edges 10..15 aborts, stays powered.
// [RULE_05] Full conversion needs sixteen clock cycles.
// [RULE_06] After sixteen, outputs stay driven.
// [RULE_07] Two more clocks give trailing zeros.
// [RULE_08] Sixteen more clocks give other channel.
// [RULE_09] Release on edge 32 or select rise.
// [RULE_10] Host waits quiet gap before next frame.
// [RULE_11] Rise in edges 2..9 enters partial down.
// [RULE_12] Rise before edge 2 ignored as glitch.
// [RULE_13] Partial down keeps only reference powered.
// [RULE_14] Dummy frame past ten wakes partial.
// [RULE_15] Early rise keeps partial power-down.
// [RULE_16] Power-up starts at fall, undone if unmet.
// [RULE_17] Partial plus window rise gives full down.
// [RULE_18] Host may skip remaining clocks.
// [RULE_19] Full wake needs dummy and long delay.
// [RULE_20] Partial wake: track after first clock edge.
// [RULE_21] Quiet gap also follows dummy frame.
// [RULE_22] Power-on mode unknown; dummy cycle advised.
// [RULE_23] Two dummies hold partial after power-on.
// [RULE_24] Three dummies reach full after power-on.
// [RULE_25] Count clock falls, classify select rise.
`timescale 1ns/1ns
module adcpm_power_ctrl
  import adcpm_pkg::*;
#(
  parameter int FULL_WAKE_CYCLES = FULL_WAKE_CYC,
  parameter int PART_WAKE_CYCLES = PART_WAKE_CYC,
  parameter int BUF_DEPTH        = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Serial pins from the host
  input  wire logic             cs_n,
  input  wire logic             sclk,
  // Serial data pins
  output adcpm_pins_type        pins,
  // Converter core results
  input  wire logic             result_valid,
  output logic                  result_ready,
  input  wire adcpm_result_type result,
  // Converter core control
  output logic                  track_hold,
  output logic                  conv_start,
  output logic                  conv_abort,
  output logic                  conv_done,
  output logic                  ref_power_on,
  output logic                  analog_power_on,
  output logic                  powered_up,
  output adcpm_mode_type        mode
);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic cs_meta_q, cs_sync_q, cs_prev_q;
  logic ck_meta_q, ck_sync_q, ck_prev_q;
  logic cs_fall, cs_rise, ck_fall, ck_rise;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      ck_meta_q <= 1'b1;
      ck_sync_q <= 1'b1;
      ck_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      ck_meta_q <= sclk;
      ck_sync_q <= ck_meta_q;
      ck_prev_q <= ck_sync_q;
    end
  end

  always_comb begin
    cs_fall = cs_prev_q & ~cs_sync_q;
    cs_rise = ~cs_prev_q & cs_sync_q;
    // A clock edge coincident with a select edge belongs to no frame.
    ck_fall = ck_prev_q & ~ck_sync_q & ~cs_sync_q & ~cs_fall;
    ck_rise = ~ck_prev_q & ck_sync_q & ~cs_sync_q & ~cs_fall;
  end

  // ********************************************************
  // Result buffer
  // ********************************************************
  logic             buf_valid;
  adcpm_result_type buf_data;

  adcpm_fifo #(
    .WIDTH (2 * RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result),
    .out_valid (buf_valid),
    .out_ready (cs_fall),
    .out_data  (buf_data)
  );

  // ********************************************************
  // Frame and mode state
  // ********************************************************
  logic [WAKE_W-1:0]  wake_cnt_q, wake_cnt_d;
  logic [CNT_W-1:0]   fall_cnt_q, fall_cnt_d;
  logic [FRAME_W-1:0] shift_a_q, shift_a_d, shift_b_q, shift_b_d;
  adcpm_mode_type     mode_q, mode_d;
  logic               frame_q, frame_d;
  logic               oe_q, oe_d;
  logic               hold_q, hold_d;
  logic               from_part_q, from_part_d;
  logic               start_q, start_d;
  logic               abort_q, abort_d;
  logic               done_q, done_d;
  logic [CNT_W-1:0]   cnt_inc;
  adcpm_result_type   word;

  always_comb begin
    mode_d      = mode_q;
    frame_d     = frame_q;
    fall_cnt_d  = fall_cnt_q;
    oe_d        = oe_q;
    hold_d      = hold_q;
    shift_a_d   = shift_a_q;
    shift_b_d   = shift_b_q;
    wake_cnt_d  = (wake_cnt_q != '0) ? wake_cnt_q - 1'b1 : wake_cnt_q;
    from_part_d = from_part_q;
    start_d     = 1'b0;
    abort_d     = 1'b0;
    done_d      = 1'b0;
    cnt_inc     = (fall_cnt_q == EDGE_SAT) ? fall_cnt_q : fall_cnt_q + 1'b1;
    word        = buf_valid ? buf_data : '0;

    if (cs_fall) begin
      // [RULE_01] Sample and drive
      frame_d     = 1'b1;
      fall_cnt_d  = '0;
      oe_d        = 1'b1;
      hold_d      = 1'b1;
      start_d     = 1'b1;
      from_part_d = (mode_q == MODE_PARTIAL);
      // [RULE_02] Zeros then result
      // [RULE_08] Other channel follows
      shift_a_d   = {LEAD_ZEROS, word.chan_a, LEAD_ZEROS, word.chan_b};
      shift_b_d   = {LEAD_ZEROS, word.chan_b, LEAD_ZEROS, word.chan_a};
    end else if (cs_rise) begin
      frame_d = 1'b0;
      // [RULE_09] Release at rise
      oe_d    = 1'b0;
      hold_d  = 1'b0;
      // [RULE_25] Classify the rise
      if (fall_cnt_q < EDGE_GLITCH) begin
        // [RULE_12] Glitch kept normal
        // [RULE_15] Partial stays partial
        mode_d = mode_q;
      end else if (fall_cnt_q < EDGE_WAKE) begin
        // [RULE_11] Enter partial down
        // [RULE_17] Partial to full
        mode_d  = (mode_q == MODE_NORMAL) ? MODE_PARTIAL : MODE_FULL;
        abort_d = 1'b1;
      end else if (fall_cnt_q < EDGE_DONE) begin
        // [RULE_04] Abort, stay powered
        abort_d = 1'b1;
      end
    end else if (frame_q) begin
      if (ck_fall) begin
        fall_cnt_d = cnt_inc;
        // [RULE_06] Keep driving past 16
        // [RULE_07] Trailing zeros shift out
        shift_a_d  = {shift_a_q[FRAME_W-2:0], 1'b0};
        shift_b_d  = {shift_b_q[FRAME_W-2:0], 1'b0};
        // [RULE_09] Release on edge 32
        if (cnt_inc == EDGE_LAST) begin
          oe_d = 1'b0;
        end
        // [RULE_05] Sixteen cycles complete
        if (cnt_inc == EDGE_DONE) begin
          done_d = 1'b1;
        end
        // [RULE_14] Wake condition met
        // [RULE_19] Long wake from full
        if (cnt_inc == EDGE_WAKE && mode_q != MODE_NORMAL) begin
          mode_d = MODE_NORMAL;
        end
      end
      // [RULE_20] Partial wake tracks early
      if ((ck_fall || ck_rise) && from_part_q) begin
        hold_d      = 1'b0;
        from_part_d = 1'b0;
      end
      // Track again on the first rising edge after the sixteenth fall.
      if (ck_rise && fall_cnt_q >= EDGE_DONE) begin
        hold_d = 1'b0;
      end
    end

    // [RULE_16] Wake timer from select fall
    if (cs_fall && mode_q == MODE_PARTIAL) begin
      wake_cnt_d = WAKE_W'(PART_WAKE_CYCLES);
    end else if (cs_fall && mode_q == MODE_FULL) begin
      wake_cnt_d = WAKE_W'(FULL_WAKE_CYCLES);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // [RULE_22] Reset picks normal
      mode_q      <= MODE_NORMAL;
      frame_q     <= 1'b0;
      fall_cnt_q  <= '0;
      oe_q        <= 1'b0;
      hold_q      <= 1'b0;
      shift_a_q   <= '0;
      shift_b_q   <= '0;
      wake_cnt_q  <= '0;
      from_part_q <= 1'b0;
      start_q     <= 1'b0;
      abort_q     <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      frame_q     <= frame_d;
      fall_cnt_q  <= fall_cnt_d;
      oe_q        <= oe_d;
      hold_q      <= hold_d;
      shift_a_q   <= shift_a_d;
      shift_b_q   <= shift_b_d;
      wake_cnt_q  <= wake_cnt_d;
      from_part_q <= from_part_d;
      start_q     <= start_d;
      abort_q     <= abort_d;
      done_q      <= done_d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  always_comb begin
    pins.serial_out_a    = shift_a_q[FRAME_W-1];
    pins.serial_out_a_oe = oe_q;
    pins.serial_out_b    = shift_b_q[FRAME_W-1];
    pins.serial_out_b_oe = oe_q;
    track_hold           = hold_q;
    conv_start           = start_q;
    conv_abort           = abort_q;
    conv_done            = done_q;
    mode                 = mode_q;
    // [RULE_13] Reference only in partial
    // [RULE_16] Frame powers up tentatively
    ref_power_on         = (mode_q != MODE_FULL) | frame_q;
    analog_power_on      = (mode_q == MODE_NORMAL) | frame_q;
    powered_up           = (mode_q == MODE_NORMAL) & (wake_cnt_q == '0);
  end

endmodule

/* test_adcpm_power_ctrl.sv */
`timescale 1ns/1ns
module test_adcpm_power_ctrl import adcpm_pkg::*;;
  // ****
  // Bench
  // ****
  typedef struct {int n; adcpm_mode_type m; logic p;} adcpm_row_type;
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             result_valid = 1'b0;
  adcpm_result_type result = 28'h0000000;
  logic             cs_n, sclk, result_ready, track_hold, conv_start, conv_abort;
  logic             conv_done, ref_power_on, analog_power_on, powered_up;
  adcpm_mode_type   mode;
  adcpm_pins_type   pins;
  logic [32:0]      la, lb;
  int               fail_count = 0;
  int               check_count = 0;
  adcpm_row_type    rows [11] = '{'{32, MODE_NORMAL, 1'b1}, '{1, MODE_NORMAL, 1'b1},
    '{5, MODE_PARTIAL, 1'b0}, '{1, MODE_PARTIAL, 1'b0}, '{5, MODE_FULL, 1'b0},
    '{9, MODE_FULL, 1'b0}, '{10, MODE_NORMAL, 1'b1}, '{2, MODE_PARTIAL, 1'b0},
    '{16, MODE_NORMAL, 1'b1}, '{15, MODE_NORMAL, 1'b1}, '{16, MODE_NORMAL, 1'b1}};

  always #5 clock = ~clock;

  adcpm_power_ctrl #(.FULL_WAKE_CYCLES(50)) i_adcpm_power_ctrl (.clock(clock),
    .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .pins(pins), .result_valid(result_valid),
    .result_ready(result_ready), .result(result), .track_hold(track_hold),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done),
    .ref_power_on(ref_power_on), .analog_power_on(analog_power_on),
    .powered_up(powered_up), .mode(mode));
  adcpm_host i_adcpm_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .pins(pins));

  task automatic check_val(input string what, input logic [32:0] e, input logic [32:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  // Bits past the last sampled one stay unknown on both sides.
  function automatic logic [32:0] line_of(input logic [13:0] x, input logic [13:0] y, int n);
    logic [32:0] v;
    for (int k = 0; k < 33; k++) begin
      v[k] = (k > n) ? 1'bx : (k == 32) ? 1'bz : (k % 16 < 2) ? 1'b0 :
        (k < 16) ? x[15 - k] : y[31 - k];
    end
    return v;
  endfunction

  task automatic push(input adcpm_result_type w);
    @(negedge clock);
    result = w;
    result_valid = 1'b1;
    @(negedge clock);
    result_valid = 1'b0;
  endtask

  task automatic send(input int n, input adcpm_result_type w);
    i_adcpm_host.frame(n, la, lb);
    check_val("line a", line_of(w.chan_a, w.chan_b, n), la);
    check_val("line b", line_of(w.chan_b, w.chan_a, n), lb);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    adcpm_result_type w;
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    check_val("mode", 33'(MODE_NORMAL), 33'(mode));
    for (int i = 0; i < 11; i++) begin
      w = {14'h2a5c ^ 14'(i), 14'h1b3e + 14'(i)};
      push(w);
      send(rows[i].n, w);
      repeat (20) @(negedge clock);
      check_val("mode", 33'(rows[i].m), 33'(mode));
      check_val("powered", 33'(rows[i].p), 33'(powered_up));
      $display("row %0d done", i);
    end
    for (int i = 0; i < 16; i++) push({14'h0100 + 14'(i), 14'h3f00 - 14'(i)});
    check_val("ready", 33'h0, 33'(result_ready));
    push(28'h0123456);
    for (int i = 0; i < 17; i++) begin
      send(16, (i < 16) ? {14'h0100 + 14'(i), 14'h3f00 - 14'(i)} : 28'h0);
    end
    $display("buffer test done");
    send(5, 28'h0);
    // A full buffer before reset shows that reset empties it.
    for (int i = 0; i < 16; i++) push(28'h0abcdef);
    check_val("ready", 33'h0, 33'(result_ready));
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    check_val("mode", 33'(MODE_NORMAL), 33'(mode));
    check_val("ready", 33'h1, 33'(result_ready));
    send(16, 28'h0);
    check_val("mode", 33'(MODE_NORMAL), 33'(mode));
    send(5, 28'h0);
    check_val("mode", 33'(MODE_PARTIAL), 33'(mode));
    send(5, 28'h0);
    check_val("mode", 33'(MODE_FULL), 33'(mode));
    $display("reset test done");
    report_and_stop();
  end
endmodule
